/* pkg/iosrd_consts.svh */
`ifndef IOSRD_CONSTS_SVH
`define IOSRD_CONSTS_SVH

// Address map of the core side.
`define IOSRD_IO_DATA_OFFSET 8'h20
`define IOSRD_BIT_IO_LAST 8'h1F
`define IOSRD_IO_LAST 8'h3F
`define IOSRD_EXT_FIRST 8'h60

// Low bit-accessible registers, given as I/O addresses.
`define IOSRD_EVT_FLAGS_IO 8'h00
`define IOSRD_EVT_MASK_IO 8'h01

// Serial register group in extended space, given as data addresses.
`define IOSRD_SER_STATUS_A 8'hC0
`define IOSRD_SER_CONTROL_B 8'hC1
`define IOSRD_SER_CONTROL_C 8'hC2
`define IOSRD_SER_BAUD_LOW 8'hC4
`define IOSRD_SER_BAUD_HIGH 8'hC5
`define IOSRD_SER_DATA_BUF 8'hC6

// Field layouts of the stored bits.
`define IOSRD_STA_TX_DONE_BIT 6
`define IOSRD_STA_RW 8'h03
`define IOSRD_STA_W1C 8'h40
`define IOSRD_CTLB_RW 8'hFD
`define IOSRD_BAUDH_RW 8'h0F
`define IOSRD_FULL_BITS 8'hFF
`define IOSRD_NO_BITS 8'h00
`define IOSRD_REG_RESET 8'h00

// Register indices of the device storage.
`define IOSRD_IDX_DATA_BUF 3'h7

// Host command port offsets.
`define IOSRD_HOST_CMD 3'h0
`define IOSRD_HOST_ADDR 3'h1
`define IOSRD_HOST_WDATA 3'h2
`define IOSRD_HOST_STATUS 3'h3
`define IOSRD_HOST_RDATA 3'h4
`define IOSRD_HOST_IRQ_STATUS 3'h5
`define IOSRD_HOST_IRQ_MASK 3'h6

`endif

/* pkg/iosrd_pkg.sv */
package iosrd_pkg;
`include "iosrd_consts.svh"

  typedef enum logic [3:0] {
    op_none,
    io_read_op,
    io_write_op,
    set_single_bit_op,
    clear_single_bit_op,
    skip_if_bit_set_op,
    skip_if_bit_clear_op,
    data_space_load_op,
    data_space_store_op
  } iosrd_op_type;

  typedef enum {st_idle, st_wait} iosrd_host_state_type;

  function automatic logic iosrd_is_data_op(iosrd_op_type op);
    return op == data_space_load_op || op == data_space_store_op;
  endfunction : iosrd_is_data_op

  function automatic logic [7:0] iosrd_data_addr(iosrd_op_type op, logic [7:0] addr);
    return iosrd_is_data_op(op) ? addr : 8'(addr + `IOSRD_IO_DATA_OFFSET);
  endfunction : iosrd_data_addr

  function automatic logic iosrd_op_legal(iosrd_op_type op, logic [7:0] addr);
    case (op)
      io_read_op, io_write_op: return addr <= `IOSRD_IO_LAST;
      set_single_bit_op, clear_single_bit_op,
      skip_if_bit_set_op, skip_if_bit_clear_op: return addr <= `IOSRD_BIT_IO_LAST;
      data_space_load_op, data_space_store_op: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : iosrd_op_legal

  // Returns the hit flag above a three-bit storage index.
  function automatic logic [3:0] iosrd_reg_index(logic [7:0] daddr);
    case (daddr)
      8'(`IOSRD_EVT_FLAGS_IO + `IOSRD_IO_DATA_OFFSET): return 4'h8;
      8'(`IOSRD_EVT_MASK_IO + `IOSRD_IO_DATA_OFFSET): return 4'h9;
      `IOSRD_SER_STATUS_A: return 4'hA;
      `IOSRD_SER_CONTROL_B: return 4'hB;
      `IOSRD_SER_CONTROL_C: return 4'hC;
      `IOSRD_SER_BAUD_LOW: return 4'hD;
      `IOSRD_SER_BAUD_HIGH: return 4'hE;
      `IOSRD_SER_DATA_BUF: return 4'hF;
      default: return 4'h0;
    endcase
  endfunction : iosrd_reg_index

  function automatic logic [7:0] iosrd_rw_bits(int idx);
    case (idx)
      0: return `IOSRD_NO_BITS;
      2: return `IOSRD_STA_RW;
      3: return `IOSRD_CTLB_RW;
      6: return `IOSRD_BAUDH_RW;
      default: return `IOSRD_FULL_BITS;
    endcase
  endfunction : iosrd_rw_bits

  function automatic logic [7:0] iosrd_w1c_bits(int idx);
    case (idx)
      0: return `IOSRD_FULL_BITS;
      2: return `IOSRD_STA_W1C;
      default: return `IOSRD_NO_BITS;
    endcase
  endfunction : iosrd_w1c_bits

  // Bits that software may write at a data address; zero means reserved.
  function automatic logic [7:0] iosrd_writable(logic [7:0] daddr);
    logic [3:0] hi;
    hi = iosrd_reg_index(daddr);
    return hi[3] ? (iosrd_rw_bits(int'(hi[2:0])) | iosrd_w1c_bits(int'(hi[2:0])))
                 : `IOSRD_NO_BITS;
  endfunction : iosrd_writable

endpackage : iosrd_pkg

/* pkg/iosrd_if.sv */
`timescale 1ns/1ps
interface iosrd_if;
  logic req;
  iosrd_pkg::iosrd_op_type op;
  logic [7:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic skip;
  logic refused;

  modport device (
    input req, op, addr, bit_sel, wdata,
    output ack, rdata, skip, refused
  );

  modport host (
    output req, op, addr, bit_sel, wdata,
    input ack, rdata, skip, refused
  );
endinterface : iosrd_if

/* design/iosrd_reg_cell.sv */
`timescale 1ns/1ps
`include "iosrd_consts.svh"
module iosrd_reg_cell #(
  parameter logic [7:0] RW_BITS = 8'hFF,
  parameter logic [7:0] W1C_BITS = 8'h00
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Write port as a per-bit mask and value
  input wire logic [7:0] wr_mask_i,
  input wire logic [7:0] wr_val_i,
  // Hardware events
  input wire logic [7:0] hw_set_i,
  // Stored value
  output logic [7:0] q_o
);
  logic [7:0] q_reg;
  logic [7:0] q_next;
  wire [7:0] ones_written = wr_mask_i & wr_val_i;

  // A flag event in the cycle of its clearing write survives.
  assign q_next = (RW_BITS & (ones_written | (~wr_mask_i & q_reg)))
                | (W1C_BITS & (hw_set_i | (q_reg & ~ones_written)));
  assign q_o = q_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q_reg <= `IOSRD_REG_RESET;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule : iosrd_reg_cell

/* design/iosrd_device.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "iosrd_consts.svh"
// Functional notes
// - Bit set and clear work on I/O 0x00-0x1F.
// - Bit test with skip works on that range.
// - Flags clear on written one, zero keeps them.
// - Bit operations touch only the addressed bit.
// - Bit operations above 0x1F are refused.
// - Direct I/O operations use 0x00-0x3F only.
// - Data space sees I/O address plus 0x20.
// - Extended 0x60-0xFF only by load and store.
// - Software writes reserved bits as zero.
// - Software never writes reserved addresses.
module iosrd_device
  import iosrd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Core link
  iosrd_if.device link,
  // Serial engine state
  input wire logic [7:0] rx_data_i,
  input wire logic rx_complete_i,
  input wire logic tx_complete_i,
  input wire logic data_empty_i,
  input wire logic [2:0] rx_error_i,
  input wire logic rx_bit8_i,
  // Block events
  input wire logic [7:0] event_i,
  // Serial engine controls
  output logic [7:0] tx_data_o,
  output logic tx_load_o,
  output logic rx_read_o,
  output logic [1:0] status_ctrl_o,
  output logic [7:0] serial_control_b_o,
  output logic [7:0] serial_control_c_o,
  output logic [11:0] baud_divisor_o,
  // Interrupt
  output logic irq_o
);
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic skip_reg;
  logic refused_reg;
  logic tx_load_reg;
  logic rx_read_reg;
  logic irq_reg;
  logic [7:0] cell_q [8];
  logic [7:0] hw_set [8];
  logic [7:0] read_view [8];

  // Decode of the request.
  wire [7:0] data_addr = iosrd_data_addr(link.op, link.addr);
  wire legal = iosrd_op_legal(link.op, link.addr);
  wire [3:0] hit_index = iosrd_reg_index(data_addr);
  wire hit = hit_index[3];
  wire [2:0] reg_index = hit_index[2:0];
  wire take = link.req & legal;
  wire op_write = link.op == io_write_op || link.op == data_space_store_op;
  wire op_set = link.op == set_single_bit_op;
  wire op_bit = op_set || link.op == clear_single_bit_op;
  wire op_skip_set = link.op == skip_if_bit_set_op;
  wire op_skip = op_skip_set || link.op == skip_if_bit_clear_op;
  wire op_read = link.op == io_read_op || link.op == data_space_load_op || op_skip;

  // Per-bit write mask and value; a bit operation never writes its neighbours.
  wire [7:0] bit_one = 8'h01 << link.bit_sel;
  wire [7:0] wr_mask = op_write ? `IOSRD_FULL_BITS : (op_bit ? bit_one : `IOSRD_NO_BITS);
  wire [7:0] wr_val = op_write ? link.wdata : (op_set ? `IOSRD_FULL_BITS : `IOSRD_NO_BITS);
  wire wr_hit = take & hit & (op_write | op_bit);

  // Read side: live engine bits are merged over the stored ones.
  assign read_view[0] = cell_q[0];
  assign read_view[1] = cell_q[1];
  assign read_view[2] = {rx_complete_i, cell_q[2][6], data_empty_i, rx_error_i, cell_q[2][1:0]};
  assign read_view[3] = {cell_q[3][7:2], rx_bit8_i, cell_q[3][0]};
  assign read_view[4] = cell_q[4];
  assign read_view[5] = cell_q[5];
  assign read_view[6] = cell_q[6] & `IOSRD_BAUDH_RW;
  assign read_view[7] = rx_data_i;
  wire [7:0] read_val = hit ? read_view[reg_index] : `IOSRD_NO_BITS;
  wire sel_bit = read_val[link.bit_sel];
  wire skip_now = take & op_skip & (sel_bit == op_skip_set);
  wire buf_hit = take & hit & (reg_index == `IOSRD_IDX_DATA_BUF);

  // Hardware sources of the sticky flags.
  assign hw_set[0] = event_i;
  assign hw_set[1] = `IOSRD_NO_BITS;
  assign hw_set[2] = 8'(tx_complete_i) << `IOSRD_STA_TX_DONE_BIT;
  assign hw_set[3] = `IOSRD_NO_BITS;
  assign hw_set[4] = `IOSRD_NO_BITS;
  assign hw_set[5] = `IOSRD_NO_BITS;
  assign hw_set[6] = `IOSRD_NO_BITS;
  assign hw_set[7] = `IOSRD_NO_BITS;

  // Storage cells; W1C positions clear on a written one only.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cell
      wire sel = wr_hit && (reg_index == 3'(gi));
      iosrd_reg_cell #(
        .RW_BITS(iosrd_rw_bits(gi)),
        .W1C_BITS(iosrd_w1c_bits(gi))
      ) u_cell (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_mask_i(sel ? wr_mask : `IOSRD_NO_BITS),
        .wr_val_i(wr_val),
        .hw_set_i(hw_set[gi]),
        .q_o(cell_q[gi])
      );
    end
  endgenerate

  // Answer to the core, one cycle after each request.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= 8'h00;
      skip_reg <= 1'b0;
    end else begin
      ack_reg <= link.req;
      refused_reg <= link.req & ~legal;
      rdata_reg <= (take & op_read) ? read_val : 8'h00;
      skip_reg <= skip_now;
    end
  end

  // Engine strobes and interrupt level.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_load_reg <= 1'b0;
      rx_read_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      tx_load_reg <= buf_hit & op_write;
      rx_read_reg <= buf_hit & op_read;
      irq_reg <= |(cell_q[0] & cell_q[1]);
    end
  end

  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;
  assign link.skip = skip_reg;
  assign link.refused = refused_reg;
  assign tx_data_o = cell_q[7];
  assign tx_load_o = tx_load_reg;
  assign rx_read_o = rx_read_reg;
  assign status_ctrl_o = cell_q[2][1:0];
  assign serial_control_b_o = cell_q[3];
  assign serial_control_c_o = cell_q[4];
  assign baud_divisor_o = {cell_q[6][3:0], cell_q[5]};
  assign irq_o = irq_reg;
endmodule : iosrd_device

/* design/iosrd_host.sv */
`timescale 1ns/1ps
`include "iosrd_consts.svh"
module iosrd_host
  import iosrd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Software port
  input wire logic [2:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  // Interrupt
  output logic irq_o,
  // Link to the decoder
  iosrd_if.host link
);
  iosrd_host_state_type state_reg;
  iosrd_op_type op_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] out_wdata_reg;
  logic [2:0] bit_sel_reg;
  logic req_reg;
  logic skip_reg;
  logic refused_reg;
  logic [7:0] result_reg;
  logic [1:0] irq_flags_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] sw_rdata_reg;
  logic irq_reg;

  wire wr_cmd = sw_wr_i && sw_addr_i == `IOSRD_HOST_CMD;
  wire [3:0] new_op_code = sw_wdata_i[3:0];
  wire iosrd_op_type new_op = iosrd_op_type'(new_op_code);
  wire [7:0] new_daddr = iosrd_data_addr(new_op, addr_reg);
  wire [7:0] new_writable = iosrd_writable(new_daddr);
  wire new_writes = new_op == io_write_op || new_op == data_space_store_op
                 || new_op == set_single_bit_op || new_op == clear_single_bit_op;
  // Reserved targets of a write are stopped here and never reach the link.
  wire new_ok = iosrd_op_legal(new_op, addr_reg)
              && !(new_writes && new_writable == `IOSRD_NO_BITS);
  wire start = wr_cmd && state_reg == st_idle;
  wire done_ev = (start & ~new_ok) | (state_reg == st_wait & link.ack);
  wire refuse_ev = (start & ~new_ok) | (state_reg == st_wait & link.ack & link.refused);
  wire clr_irq = sw_wr_i && sw_addr_i == `IOSRD_HOST_IRQ_STATUS;
  wire [1:0] irq_clear = clr_irq ? sw_wdata_i[1:0] : 2'b00;

  logic [7:0] sw_read_val;
  always_comb begin
    case (sw_addr_i)
      `IOSRD_HOST_ADDR: sw_read_val = addr_reg;
      `IOSRD_HOST_WDATA: sw_read_val = wdata_reg;
      `IOSRD_HOST_STATUS: sw_read_val = {5'h00, refused_reg, skip_reg, state_reg == st_wait};
      `IOSRD_HOST_RDATA: sw_read_val = result_reg;
      `IOSRD_HOST_IRQ_STATUS: sw_read_val = {6'h00, irq_flags_reg};
      `IOSRD_HOST_IRQ_MASK: sw_read_val = {6'h00, irq_mask_reg};
      default: sw_read_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= st_idle;
      req_reg <= 1'b0;
    end else begin
      req_reg <= start & new_ok;
      case (state_reg)
        st_idle: if (start && new_ok) state_reg <= st_wait;
        st_wait: if (link.ack) state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      op_reg <= op_none;
      bit_sel_reg <= 3'h0;
      out_wdata_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      irq_mask_reg <= 2'b00;
    end else begin
      if (start) begin
        op_reg <= new_op;
        bit_sel_reg <= sw_wdata_i[6:4];
        out_wdata_reg <= wdata_reg & new_writable;
      end
      if (sw_wr_i && sw_addr_i == `IOSRD_HOST_ADDR) addr_reg <= sw_wdata_i;
      if (sw_wr_i && sw_addr_i == `IOSRD_HOST_WDATA) wdata_reg <= sw_wdata_i;
      if (sw_wr_i && sw_addr_i == `IOSRD_HOST_IRQ_MASK) irq_mask_reg <= sw_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      skip_reg <= 1'b0;
      refused_reg <= 1'b0;
      result_reg <= 8'h00;
      irq_flags_reg <= 2'b00;
      sw_rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      if (done_ev) begin
        skip_reg <= link.ack & link.skip;
        refused_reg <= refuse_ev;
        result_reg <= link.ack ? link.rdata : 8'h00;
      end
      irq_flags_reg <= {refuse_ev, done_ev} | (irq_flags_reg & ~irq_clear);
      sw_rdata_reg <= sw_rd_i ? sw_read_val : 8'h00;
      irq_reg <= |(irq_flags_reg & irq_mask_reg);
    end
  end

  assign link.req = req_reg;
  assign link.op = op_reg;
  assign link.addr = addr_reg;
  assign link.bit_sel = bit_sel_reg;
  assign link.wdata = out_wdata_reg;
  assign sw_rdata_o = sw_rdata_reg;
  assign irq_o = irq_reg;
endmodule : iosrd_host

/* bench/iosrd_assertions.sv */
`timescale 1ns/1ps
module iosrd_assertions
  import iosrd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link signals
  input wire logic req,
  input wire iosrd_op_type op,
  input wire logic [7:0] addr,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic refused
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  wire bit_op;
  wire io_op;
  wire test_op;
  wire data_op;
  wire resv_load;
  assign test_op = op inside {skip_if_bit_set_op, skip_if_bit_clear_op};
  assign bit_op = test_op || op inside {set_single_bit_op, clear_single_bit_op};
  assign io_op = op inside {io_read_op, io_write_op};
  assign data_op = op inside {data_space_load_op, data_space_store_op};
  assign resv_load = op == data_space_load_op && (addr == 8'hC3 || addr > 8'hC6);
  // The host waits for each answer, so a request never repeats back to back.
  a_ack_follows: assert property (req |=> ack && !req)
    else $error("no single answer after request");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("answer without request");
  a_bit_range: assert property (req && bit_op |-> addr <= 8'h1F)
    else $error("bit op above low range");
  a_io_range: assert property (req && io_op |-> addr <= 8'h3F)
    else $error("direct op above io window");
  a_bit_accepted: assert property (req && bit_op |=> ack && !refused)
    else $error("low bit op refused");
  a_skip_value: assert property (ack && $past(test_op) |->
    skip == (rdata[$past(bit_sel)] ^ ($past(op) == skip_if_bit_clear_op)))
    else $error("skip does not match tested bit");
  a_skip_only_tests: assert property (ack && !$past(test_op) |-> !skip)
    else $error("skip on non test op");
  a_data_accepted: assert property (req && data_op |=> ack && !refused)
    else $error("data space op refused");
  a_reserved_zero: assert property (req && resv_load |=> rdata == 8'h00)
    else $error("reserved location read nonzero");
endmodule : iosrd_assertions

/* bench/io_space_register_decode_tb.sv */
`timescale 1ns/1ps
`include "iosrd_consts.svh"
module io_space_register_decode_tb
  import iosrd_pkg::*;
;
  typedef struct {
    iosrd_op_type op;
    logic [2:0] b;
    logic [7:0] a, d, rd;
    logic [2:0] st;
  } iosrd_row_type;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] sw_addr_i = 3'h0;
  logic [7:0] sw_wdata_i = 8'h00;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [7:0] event_i = 8'h00;
  logic tx_complete_i = 1'b0;
  logic [7:0] rx_data = 8'h5A;
  logic rx_complete = 1'b0;
  logic data_empty = 1'b1;
  logic [2:0] rx_error = 3'h5;
  logic rx_bit8 = 1'b1;
  logic [7:0] sw_rdata_o;
  logic [7:0] tx_data_o;
  logic [7:0] ctl_b;
  logic [7:0] ctl_c;
  logic [11:0] baud;
  logic [1:0] sta_ctl;
  logic h_irq;
  logic d_irq;
  logic tx_load;
  logic rx_read;
  int failures = 0;
  int num_checks = 0;
  int tx_loads = 0;
  int rx_reads = 0;
  iosrd_row_type rows [24] = '{
    '{data_space_store_op, 0, 8'hC2, 8'hA5, 8'h00, 0},
    '{data_space_load_op, 0, 8'hC2, 8'h00, 8'hA5, 0},
    '{io_write_op, 0, 8'hA2, 8'h11, 8'h00, 4},
    '{io_write_op, 0, 8'h01, 8'hFF, 8'h00, 0},
    '{data_space_load_op, 0, 8'h21, 8'h00, 8'hFF, 0},
    '{clear_single_bit_op, 3, 8'h01, 8'h00, 8'h00, 0},
    '{io_read_op, 0, 8'h01, 8'h00, 8'hF7, 0},
    '{skip_if_bit_set_op, 3, 8'h01, 8'h00, 8'hF7, 0},
    '{skip_if_bit_clear_op, 3, 8'h01, 8'h00, 8'hF7, 2},
    '{skip_if_bit_set_op, 0, 8'h01, 8'h00, 8'hF7, 2},
    '{set_single_bit_op, 3, 8'h01, 8'h00, 8'h00, 0},
    '{io_read_op, 0, 8'h01, 8'h00, 8'hFF, 0},
    '{set_single_bit_op, 0, 8'h20, 8'h00, 8'h00, 4},
    '{data_space_load_op, 0, 8'hC3, 8'h00, 8'h00, 0},
    '{data_space_store_op, 0, 8'hC3, 8'hFF, 8'h00, 4},
    '{data_space_store_op, 0, 8'hC5, 8'hFF, 8'h00, 0},
    '{data_space_load_op, 0, 8'hC5, 8'h00, 8'h0F, 0},
    '{data_space_store_op, 0, 8'hC1, 8'hFF, 8'h00, 0},
    '{data_space_load_op, 0, 8'hC1, 8'h00, 8'hFF, 0},
    '{data_space_store_op, 0, 8'hC6, 8'h3C, 8'h00, 0},
    '{data_space_load_op, 0, 8'hC6, 8'h00, 8'h5A, 0},
    '{op_none, 0, 8'h00, 8'h00, 8'h00, 4},
    '{io_read_op, 0, 8'h3F, 8'h00, 8'h00, 0},
    '{data_space_load_op, 0, 8'hFF, 8'h00, 8'h00, 0}
  };
  iosrd_if u_link();
  iosrd_if u_raw();
  always #12.5 clk_sys_i = ~clk_sys_i;
  iosrd_host u_iosrd_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .irq_o(h_irq), .link(u_link));
  // Serial receive inputs start at known levels and change once so live bits are seen.
  iosrd_device u_iosrd_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_link),
    .rx_data_i(rx_data), .rx_complete_i(rx_complete), .tx_complete_i(tx_complete_i),
    .data_empty_i(data_empty), .rx_error_i(rx_error), .rx_bit8_i(rx_bit8), .event_i(event_i),
    .tx_data_o(tx_data_o), .tx_load_o(tx_load), .rx_read_o(rx_read), .status_ctrl_o(sta_ctl),
    .serial_control_b_o(ctl_b), .serial_control_c_o(ctl_c), .baud_divisor_o(baud),
    .irq_o(d_irq));
  // The second device faces the bench directly, which breaks the range rules on purpose.
  iosrd_device u_iosrd_device_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(u_raw),
    .rx_data_i(rx_data), .rx_complete_i(rx_complete), .tx_complete_i(tx_complete_i),
    .data_empty_i(data_empty), .rx_error_i(rx_error), .rx_bit8_i(rx_bit8),
    .event_i(event_i), .tx_data_o(), .tx_load_o(),
    .rx_read_o(), .status_ctrl_o(), .serial_control_b_o(), .serial_control_c_o(),
    .baud_divisor_o(), .irq_o());
  // Engine strobes last one cycle, so they are counted on the falling edge, away from updates.
  always @(negedge clk_sys_i) begin
    if (tx_load === 1'b1) tx_loads++;
    if (rx_read === 1'b1) rx_reads++;
  end
  iosrd_assertions u_iosrd_assertions (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .req(u_link.req), .op(u_link.op), .addr(u_link.addr), .bit_sel(u_link.bit_sel),
    .wdata(u_link.wdata), .ack(u_link.ack), .rdata(u_link.rdata), .skip(u_link.skip),
    .refused(u_link.refused));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_wr_i <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask : sw_rd
  task automatic core(input iosrd_op_type o, input logic [2:0] b, input logic [7:0] a, d,
                      output logic [7:0] rd, output logic [2:0] st);
    int n;
    logic [7:0] s;
    n = 0;
    sw_wr(`IOSRD_HOST_ADDR, a);
    sw_wr(`IOSRD_HOST_WDATA, d);
    sw_wr(`IOSRD_HOST_CMD, {1'b0, b, o});
    do begin
      sw_rd(`IOSRD_HOST_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 20);
    if (s[0] !== 1'b0) begin
      failures++;
      tally_and_finish();
    end
    st = s[2:0];
    sw_rd(`IOSRD_HOST_RDATA, rd);
  endtask : core
  task automatic ld(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] rd;
    logic [2:0] st;
    core(data_space_load_op, 3'h0, a, 8'h00, rd, st);
    chk_val("load", e, rd);
  endtask : ld
  task automatic run(input iosrd_op_type o, input logic [2:0] b, input logic [7:0] a, d);
    logic [7:0] rd;
    logic [2:0] st;
    core(o, b, a, d, rd, st);
  endtask : run
  task automatic raw(input iosrd_op_type o, input logic [7:0] a, input logic e);
    @(posedge clk_sys_i);
    u_raw.req <= 1'b1;
    u_raw.op <= o;
    u_raw.addr <= a;
    @(posedge clk_sys_i);
    u_raw.req <= 1'b0;
    #1 chk_val("raw refused", {1'b1, e}, {u_raw.ack, u_raw.refused});
  endtask : raw
  initial begin
    logic [7:0] rd;
    logic [2:0] st;
    u_raw.req = 1'b0;
    u_raw.op = op_none;
    u_raw.addr = 8'h00;
    u_raw.bit_sel = 3'h0;
    u_raw.wdata = 8'h00;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      core(rows[i].op, rows[i].b, rows[i].a, rows[i].d, rd, st);
      chk_val("status", rows[i].st, st);
      if (!rows[i].st[2]) chk_val("rdata", rows[i].rd, rd);
    end
    chk_val("baud", 12'hF00, baud);
    chk_val("control b", 12'h0FD, {4'h0, ctl_b});
    chk_val("control c", 12'h0A5, {4'h0, ctl_c});
    chk_val("tx data", 12'h03C, {4'h0, tx_data_o});
    chk_val("tx loads", 12'h001, 12'(tx_loads));
    chk_val("rx reads", 12'h001, 12'(rx_reads));
    $display("test table done");
    @(posedge clk_sys_i);
    event_i <= 8'h81;
    tx_complete_i <= 1'b1;
    @(posedge clk_sys_i);
    event_i <= 8'h00;
    tx_complete_i <= 1'b0;
    ld(8'h20, 8'h81);
    ld(8'hC0, 8'h74);
    run(data_space_store_op, 3'h0, 8'hC0, 8'h43);
    ld(8'hC0, 8'h37);
    chk_val("status control", 12'h003, {10'h000, sta_ctl});
    run(io_write_op, 3'h0, 8'h00, 8'h01);
    ld(8'h20, 8'h80);
    run(clear_single_bit_op, 3'h0, 8'h00, 8'h00);
    ld(8'h20, 8'h80);
    @(posedge clk_sys_i);
    event_i <= 8'h01;
    @(posedge clk_sys_i);
    event_i <= 8'h00;
    run(set_single_bit_op, 3'h7, 8'h00, 8'h00);
    ld(8'h20, 8'h01);
    chk_val("device irq", 1'b1, d_irq);
    @(posedge clk_sys_i);
    rx_data <= 8'hC3;
    rx_complete <= 1'b1;
    data_empty <= 1'b0;
    rx_error <= 3'h2;
    rx_bit8 <= 1'b0;
    ld(8'hC0, 8'h8B);
    ld(8'hC1, 8'hFD);
    ld(8'hC6, 8'hC3);
    chk_val("rx reads", 12'h002, 12'(rx_reads));
    $display("test flags done");
    sw_wr(`IOSRD_HOST_IRQ_STATUS, 8'h03);
    sw_wr(`IOSRD_HOST_IRQ_MASK, 8'h02);
    run(set_single_bit_op, 3'h0, 8'h20, 8'h00);
    sw_rd(`IOSRD_HOST_IRQ_STATUS, rd);
    chk_val("irq status", 8'h03, rd);
    chk_val("host irq", 1'b1, h_irq);
    sw_wr(`IOSRD_HOST_IRQ_STATUS, 8'h02);
    @(posedge clk_sys_i);
    #1 chk_val("host irq", 1'b0, h_irq);
    sw_rd(3'h7, rd);
    chk_val("host gap", 8'h00, rd);
    $display("test interrupt done");
    raw(set_single_bit_op, 8'h20, 1'b1);
    raw(io_write_op, 8'h40, 1'b1);
    raw(op_none, 8'h00, 1'b1);
    raw(data_space_store_op, 8'hE0, 1'b0);
    raw(skip_if_bit_set_op, 8'h1F, 1'b0);
    $display("test range done");
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    @(posedge clk_sys_i);
    #1 chk_val("outputs", 12'h000, {d_irq, h_irq, sta_ctl, ctl_c});
    chk_val("reset data", 12'h000, {4'h0, tx_data_o});
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    ld(8'hC2, 8'h00);
    ld(8'h21, 8'h00);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : io_space_register_decode_tb
